// ---- tbscr_pkg.sv ----
// Package: register map, field positions and constants of the 10 Mb/s control block
package tbscr_pkg;

	localparam logic [4:0]  TBSCR_ADDR_TEN_CTRL = 5'h1a;
	localparam logic [4:0]  TBSCR_ADDR_DRV_TEST = 5'h1b;

	// Ten meg control register fields
	localparam int          TBSCR_SERIAL_BIT    = 15;
	localparam int          TBSCR_SQL_LSB       = 9;
	localparam int          TBSCR_LBDIS_BIT     = 8;
	localparam int          TBSCR_LPDIS_BIT     = 7;
	localparam int          TBSCR_FLINK_BIT     = 6;
	localparam int          TBSCR_POL_BIT       = 4;
	localparam int          TBSCR_RSV1_BIT      = 2;
	localparam int          TBSCR_HBDIS_BIT     = 1;
	localparam int          TBSCR_JABDIS_BIT    = 0;
	localparam logic [2:0]  TBSCR_SQL_RST       = 3'h4;
	localparam logic [15:0] TBSCR_CTRL_WMASK    = 16'h8fc7;
	localparam logic [15:0] TBSCR_RSV_ONE_MASK  = 16'h0004;

	// Driver test register fields
	localparam int          TBSCR_ERRCNT_LSB    = 8;
	localparam int          TBSCR_CONT_BIT      = 5;
	localparam int          TBSCR_PATEN_BIT     = 4;
	localparam int          TBSCR_GAP_BIT       = 2;
	localparam int          TBSCR_PATSEL_LSB    = 0;
	localparam logic [7:0]  TBSCR_ERRCNT_MAX    = 8'hff;

	// Gap between test sequences
	localparam int          TBSCR_CLK_MHZ       = 50;
	localparam int          TBSCR_GAP_LONG_US   = 15;
	localparam int          TBSCR_GAP_SHORT_US  = 10;
	localparam int          TBSCR_GAP_LONG_CYC  = TBSCR_GAP_LONG_US * TBSCR_CLK_MHZ;
	localparam int          TBSCR_GAP_SHORT_CYC = TBSCR_GAP_SHORT_US * TBSCR_CLK_MHZ;
	localparam int          TBSCR_GAP_W         = 10;

	typedef enum logic [1:0]
	{
		TBSCR_PAT_DATA_END_OF_PACKET_TYPE_ZERO = 2'b00,
		TBSCR_PAT_DATA_END_OF_PACKET_TYPE_ONE = 2'b01,
		TBSCR_PAT_LINK      = 2'b10,
		TBSCR_PAT_TONE      = 2'b11
	} tbscr_pat_t;

	// Control outputs towards the 10 Mb/s datapath
	typedef struct packed
	{
		logic       serial_if_mode;
		logic [2:0] squelch_sel;
		logic       echo_enable;
		logic       link_pulse_tx_en;
		logic       link_ok_10;
		logic       heartbeat_en;
		logic       jabber_en;
	} tbscr_ten_ctl_t;

	// Self-test and pattern controls
	typedef struct packed
	{
		logic       selftest_continuous;
		logic       driver_pattern_enable;
		tbscr_pat_t driver_pattern_select;
		logic       gap_active;
	} tbscr_test_ctl_t;

endpackage

// ---- tbscr_gap_timer.sv ----
// Gap timer spacing successive common driver test sequences
module tbscr_gap_timer
	import tbscr_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control
	input  wire logic run,
	input  wire logic long_gap,
	input  wire logic seq_done,
	// Status
	output logic      gap_active
);

	logic [TBSCR_GAP_W-1:0] cnt_r;
	logic [TBSCR_GAP_W-1:0] cnt_nxt;
	logic                   act_r;
	logic                   act_nxt;

	always_comb
	begin
		cnt_nxt = cnt_r;
		act_nxt = act_r;
		if (!run)
		begin
			cnt_nxt = '0;
			act_nxt = 1'b0;
		end
		else if (seq_done && !act_r)
		begin
			// Count loaded from gap choice
			cnt_nxt = long_gap ? TBSCR_GAP_W'(TBSCR_GAP_LONG_CYC - 1)
			                   : TBSCR_GAP_W'(TBSCR_GAP_SHORT_CYC - 1);
			act_nxt = 1'b1;
		end
		else if (act_r)
		begin
			if (cnt_r == '0)
				act_nxt = 1'b0;
			else
				cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_r <= '0;
			act_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			act_r <= act_nxt;
		end
	end

	assign gap_active = act_r;

endmodule // tbscr_gap_timer

// ---- tbscr_regs.sv ----
// 10 Mb/s control register and driver test / self-test extension register
//
// Functional notes
// - Serial mode bit 15 puts 10 Mb/s paths into serial interface mode.
// - Bits 11:9 pick squelch threshold, reset value 100.
// - Half duplex 10 Mb/s echoes transmit to receive unless bit 8 set.
// - Bit 7 set stops normal link pulses.
// - Bit 6 set forces good 10 Mb/s link status.
// - Bit 4 latches inverted polarity; reading this register clears both copies.
// - Bit 1 disables heartbeat; off anyway at 100 Mb/s or full duplex.
// - Bit 0 disables jabber protection in 10 Mb/s operation.
// - Read-only eight-bit errored nibble counter, cleared when self-test restarts.
// - Error counter saturates at its maximum.
// - Bit 5 makes packet self-test transmit continuously.
// - Bit 4 of test register enables driver test patterns.
// - Bit 2 picks 15 us or 10 us gap between test sequences.
// - Bits 1:0 choose data/end_of_packet_type_zero, data/end_of_packet_type_one, link pulses or tone.
// - Self-test pass flag latches each result; clears when self-test stops or a later done reports fail.
module tbscr_regs
	import tbscr_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// Management register access
	input  wire logic [4:0]      reg_addr,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	input  wire logic [15:0]     reg_wdata,
	output logic      [15:0]     reg_rdata,
	output logic      [15:0]     phy_status_polarity,
	// Strap
	input  wire logic            strap_serial,
	// Datapath status
	input  wire logic            polarity_inverted,
	input  wire logic            link_ok_raw,
	input  wire logic            speed_100,
	input  wire logic            full_duplex,
	input  wire logic            phy_status_rd,
	// Self-test
	input  wire logic            selftest_start,
	input  wire logic            selftest_done,
	input  wire logic            selftest_pass,
	input  wire logic            nibble_error,
	output logic                 selftest_pass_flag,
	// Pattern generator
	input  wire logic            pattern_seq_done,
	// Controls
	output tbscr_ten_ctl_t       ten_ctl,
	output tbscr_test_ctl_t      test_ctl
);

	logic [15:0]     ctrl_r;
	logic [15:0]     ctrl_nxt;
	logic            pol_r;
	logic            pol_nxt;
	logic [7:0]      errcnt_r;
	logic [7:0]      errcnt_nxt;
	logic [5:0]      test_r;
	logic [5:0]      test_nxt;
	logic            pass_r;
	logic            pass_nxt;
	logic            start_q_r;
	logic            start_q_nxt;
	logic            strap_done_r;
	logic            strap_done_nxt;
	logic            strap_meta_r;
	logic            strap_sync_r;
	logic            gap_run;
	logic [15:0]     rdata_r;
	logic [15:0]     rdata_nxt;
	tbscr_ten_ctl_t  ten_r;
	tbscr_ten_ctl_t  ten_nxt;
	tbscr_test_ctl_t tst_r;
	tbscr_test_ctl_t tst_nxt;
	logic            gap_act;
	logic            rd_ctrl;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
		return a == r;
	endfunction

	assign rd_ctrl = reg_rd && hit(reg_addr, TBSCR_ADDR_TEN_CTRL);

	// Tone is one unbroken sequence, so it never waits out a gap
	assign gap_run = test_r[TBSCR_PATEN_BIT]
	                 && test_r[TBSCR_PATSEL_LSB +: 2] != TBSCR_PAT_TONE;

	always_comb
	begin
		ctrl_nxt   = ctrl_r;
		pol_nxt    = pol_r;
		errcnt_nxt = errcnt_r;
		test_nxt   = test_r;
		pass_nxt   = pass_r;
		rdata_nxt  = rdata_r;
		start_q_nxt    = selftest_start;
		strap_done_nxt = 1'b1;
		// Strap caught once after reset release
		if (!strap_done_r)
			ctrl_nxt[TBSCR_SERIAL_BIT] = strap_sync_r;
		if (reg_wr && hit(reg_addr, TBSCR_ADDR_TEN_CTRL))
			ctrl_nxt = reg_wdata & TBSCR_CTRL_WMASK;
		if (reg_wr && hit(reg_addr, TBSCR_ADDR_DRV_TEST))
			test_nxt = reg_wdata[5:0];
		// Read clears polarity latch, but a new event wins
		if (rd_ctrl)
			pol_nxt = 1'b0;
		if (polarity_inverted)
			pol_nxt = 1'b1;
		// Restart clears count; saturate at max
		// Clear beats a same-cycle error, so a restart always reads zero
		if (selftest_start && !start_q_r)
			errcnt_nxt = '0;
		else if (selftest_start && nibble_error
		         && errcnt_r != TBSCR_ERRCNT_MAX)
			errcnt_nxt = errcnt_r + 8'h01;
		// Pass flag holds the last done result until self-test stops
		if (!selftest_start)
			pass_nxt = 1'b0;
		else if (selftest_done)
			pass_nxt = selftest_pass;
		if (reg_rd)
		begin
			rdata_nxt = '0;
			if (hit(reg_addr, TBSCR_ADDR_TEN_CTRL))
			begin
				rdata_nxt = ctrl_r | TBSCR_RSV_ONE_MASK;
				rdata_nxt[TBSCR_POL_BIT] = pol_r;
			end
			else if (hit(reg_addr, TBSCR_ADDR_DRV_TEST))
				rdata_nxt = {errcnt_r, 2'b00, test_r};
		end
	end

	always_comb
	begin
		ten_nxt.serial_if_mode   = ctrl_r[TBSCR_SERIAL_BIT];
		ten_nxt.squelch_sel      = ctrl_r[TBSCR_SQL_LSB +: 3];
		// Echo only in 10 Mb/s half duplex
		ten_nxt.echo_enable      = !ctrl_r[TBSCR_LBDIS_BIT]
		                           && !speed_100 && !full_duplex;
		ten_nxt.link_pulse_tx_en = !ctrl_r[TBSCR_LPDIS_BIT];
		ten_nxt.link_ok_10       = ctrl_r[TBSCR_FLINK_BIT]
		                           || link_ok_raw;
		// Heartbeat never at 100 Mb/s or full duplex
		ten_nxt.heartbeat_en     = !ctrl_r[TBSCR_HBDIS_BIT]
		                           && !speed_100 && !full_duplex;
		ten_nxt.jabber_en        = !ctrl_r[TBSCR_JABDIS_BIT]
		                           && !speed_100;
		tst_nxt.selftest_continuous   = test_r[TBSCR_CONT_BIT];
		tst_nxt.driver_pattern_enable = test_r[TBSCR_PATEN_BIT];
		tst_nxt.driver_pattern_select =
			tbscr_pat_t'(test_r[TBSCR_PATSEL_LSB +: 2]);
		tst_nxt.gap_active            = gap_act;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl_r       <= {4'h0, TBSCR_SQL_RST, 9'h000};
			pol_r        <= 1'b0;
			errcnt_r     <= '0;
			test_r       <= '0;
			pass_r       <= 1'b0;
			start_q_r    <= 1'b0;
			strap_done_r <= 1'b0;
			rdata_r      <= '0;
			ten_r        <= '0;
			tst_r        <= '0;
		end
		else
		begin
			ctrl_r       <= ctrl_nxt;
			pol_r        <= pol_nxt;
			errcnt_r     <= errcnt_nxt;
			test_r       <= test_nxt;
			pass_r       <= pass_nxt;
			start_q_r    <= start_q_nxt;
			strap_done_r <= strap_done_nxt;
			rdata_r      <= rdata_nxt;
			ten_r        <= ten_nxt;
			tst_r        <= tst_nxt;
		end
	end

	// Strap pin comes in over two flops; kept out of reset so the
	// pin has settled into the pair by the time reset lets go
	always_ff @(posedge clk)
	begin
		strap_meta_r <= strap_serial;
		strap_sync_r <= strap_meta_r;
	end

	// Gap counter only runs while a sequence pattern is active
	tbscr_gap_timer u_gap
	(
		.clk        (clk),
		.rst        (rst),
		.run        (gap_run),
		.long_gap   (test_r[TBSCR_GAP_BIT]),
		.seq_done   (pattern_seq_done),
		.gap_active (gap_act)
	);

	assign reg_rdata           = rdata_r;
	// Status copy is not cleared by its own read, so the status read
	// strobe is deliberately left unused here
	assign phy_status_polarity = {3'h0, pol_r, 12'h000};
	assign selftest_pass_flag  = pass_r;
	assign ten_ctl             = ten_r;
	assign test_ctl            = tst_r;

endmodule // tbscr_regs

// ---- tbscr_regs_sva.sv ----
// Checker of the 10 Mb/s control register block outputs
module tbscr_regs_chk
	import tbscr_pkg::*;
(
	// Clock and reset
	input wire logic            clk,
	input wire logic            rst,
	// Register access
	input wire logic [4:0]      reg_addr,
	input wire logic            reg_wr,
	input wire logic            reg_rd,
	input wire logic [15:0]     reg_wdata,
	input wire logic [15:0]     reg_rdata,
	input wire logic [15:0]     phy_status_polarity,
	// Status and controls
	input wire logic            polarity_inverted,
	input wire logic            speed_100,
	input wire logic            full_duplex,
	input wire logic            selftest_start,
	input wire logic            selftest_pass_flag,
	input wire tbscr_ten_ctl_t  ten_ctl,
	input wire tbscr_test_ctl_t test_ctl
);
	timeunit 1ns;
	timeprecision 1ns;
	// Shadows of written words; serial bit is copied but never checked, it comes from a strap
	logic [15:0] sh_r, sh_nxt, tsh_r, tsh_nxt;
	always_comb
	begin
		sh_nxt  = sh_r;
		tsh_nxt = tsh_r;
		if (reg_wr && reg_addr == TBSCR_ADDR_TEN_CTRL)
			sh_nxt = reg_wdata;
		if (reg_wr && reg_addr == TBSCR_ADDR_DRV_TEST)
			tsh_nxt = reg_wdata;
		if (rst)
		begin
			sh_nxt  = 16'h0800;
			tsh_nxt = 16'h0000;
		end
	end
	always_ff @(posedge clk)
	begin
		sh_r  <= sh_nxt;
		tsh_r <= tsh_nxt;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	rsv_read_a:
	assert property (reg_rd && reg_addr == TBSCR_ADDR_TEN_CTRL |=>
		(reg_rdata & 16'h7028) == 16'h0000 && reg_rdata[2])
		else $error("reserved bits wrong");
	squelch_map_a:
	assert property (!$past(rst) |-> ten_ctl.squelch_sel == $past(sh_r[11:9]))
		else $error("squelch select wrong");
	link_pulse_a:
	assert property (!$past(rst) |-> ten_ctl.link_pulse_tx_en != $past(sh_r[7]))
		else $error("link pulse enable wrong");
	force_link_a:
	assert property (!$past(rst) && $past(sh_r[6]) |-> ten_ctl.link_ok_10)
		else $error("forced link missing");
	heartbeat_gate_a:
	assert property (!$past(rst) && $stable(speed_100) && $stable(full_duplex)
		|-> ten_ctl.heartbeat_en == (!$past(sh_r[1]) && !speed_100 && !full_duplex))
		else $error("heartbeat enable wrong");
	jabber_gate_a:
	assert property (!$past(rst) && !speed_100 && $stable(speed_100)
		|-> ten_ctl.jabber_en != $past(sh_r[0]))
		else $error("jabber enable wrong");
	pattern_ctl_a:
	assert property (!reg_wr |=> test_ctl[4:1] == {$past(tsh_r[5:4]), $past(tsh_r[1:0])})
		else $error("test controls wrong");
	polarity_set_a:
	assert property (polarity_inverted |-> ##[1:2] phy_status_polarity == 16'h1000)
		else $error("polarity copy not set");
	pass_clear_a:
	assert property (!selftest_start |=> !selftest_pass_flag)
		else $error("pass flag not cleared");
	cover property (reg_wr && reg_addr == TBSCR_ADDR_TEN_CTRL);
	cover property (test_ctl.gap_active && test_ctl.driver_pattern_enable);
	cover property (polarity_inverted ##2 reg_rd);
endmodule // tbscr_regs_chk

bind tbscr_regs tbscr_regs_chk chk_i (.clk, .rst, .reg_addr, .reg_wr, .reg_rd,
	.reg_wdata, .reg_rdata, .phy_status_polarity, .polarity_inverted,
	.speed_100, .full_duplex, .selftest_start, .selftest_pass_flag,
	.ten_ctl, .test_ctl);

// ---- test_tbscr_regs.sv ----
// Self-checking bench of the 10 Mb/s control registers
module test_tbscr_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import tbscr_pkg::*;
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, strap_serial = 1;
	logic polarity_inverted = 0, link_ok_raw = 0, speed_100 = 0;
	logic full_duplex = 0, phy_status_rd = 0, selftest_start = 0;
	logic selftest_done = 0, selftest_pass = 0, nibble_error = 0;
	logic pattern_seq_done = 0, selftest_pass_flag;
	logic [4:0]      reg_addr = 5'h00;
	logic [15:0]     reg_wdata = 16'h0000, reg_rdata, phy_status_polarity;
	tbscr_ten_ctl_t  ten_ctl;
	tbscr_test_ctl_t test_ctl;
	integer seed = 76237, miscompares = 0, checks_done = 0;
	integer m_ctl = 'h8800, m_tst = 0, m_pol = 0, m_cnt = 0, d, t, n, k;
	tbscr_regs uut (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .phy_status_polarity, .strap_serial, .polarity_inverted,
		.link_ok_raw, .speed_100, .full_duplex, .phy_status_rd,
		.selftest_start, .selftest_done, .selftest_pass, .nibble_error,
		.selftest_pass_flag, .pattern_seq_done, .ten_ctl, .test_ctl);
	always #10 clk = ~clk;
	task chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [4:0] a, input integer v);
		@(negedge clk);
		reg_addr  = a;
		reg_wdata = 16'(v);
		reg_wr    = 1;
		@(negedge clk);
		reg_wr = 0;
		if (a == TBSCR_ADDR_TEN_CTRL)
			m_ctl = v;
		if (a == TBSCR_ADDR_DRV_TEST)
			m_tst = v;
	endtask
	task rd(input logic [4:0] a);
		logic [15:0] e;
		e = 16'h0000;
		if (a == TBSCR_ADDR_DRV_TEST)
			e = 16'((m_cnt << 8) | (m_tst & 'h37));
		if (a == TBSCR_ADDR_TEN_CTRL)
			e = 16'((m_ctl & 'h8fc7) | 4 | (m_pol << 4));
		m_pol = a == TBSCR_ADDR_TEN_CTRL ? 0 : m_pol;
		@(negedge clk);
		reg_addr = a;
		reg_rd   = 1;
		@(negedge clk);
		reg_rd = 0;
		@(negedge clk);
		chk(reg_rdata, e);
	endtask
	task report_and_stop;
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(negedge clk);
		rst = 0;
		@(negedge clk);
		rd(TBSCR_ADDR_TEN_CTRL);
		rd(TBSCR_ADDR_DRV_TEST);
		repeat (8)
		begin
			d = $random(seed) & 'h8fc7 | 4;
			t = $random(seed) & (d[0] ? 'h37 : 'h17);
			{speed_100, full_duplex, link_ok_raw} = 3'($random(seed));
			wr(TBSCR_ADDR_TEN_CTRL, d);
			wr(TBSCR_ADDR_DRV_TEST, t);
			wr(5'h1c, 'hffff);
			rd(TBSCR_ADDR_TEN_CTRL);
			rd(5'h1c);
			rd(TBSCR_ADDR_DRV_TEST);
			chk(16'(ten_ctl), 16'({d[15], d[11:9],
				!d[8] && !full_duplex && !speed_100, !d[7],
				d[6] || link_ok_raw, !d[1] && !speed_100 && !full_duplex,
				!d[0] && !speed_100}));
			chk(16'(test_ctl[4:1]), 16'({t[5:4], t[1:0]}));
		end
		polarity_inverted = 1;
		@(negedge clk);
		polarity_inverted = 0;
		phy_status_rd = 1;
		m_pol = 1;
		repeat (3) @(negedge clk);
		phy_status_rd = 0;
		chk(phy_status_polarity, 16'h1000);
		rd(TBSCR_ADDR_TEN_CTRL);
		rd(TBSCR_ADDR_TEN_CTRL);
		chk(phy_status_polarity, 16'h0000);
		// Saturating run first, so the short run proves the restart clear
		for (k = 0; k < 2; k++)
		begin
			selftest_start = 0;
			@(negedge clk);
			selftest_start = 1;
			repeat (k ? 5 : 300)
			begin
				@(negedge clk);
				nibble_error = 1;
				@(negedge clk);
				nibble_error = 0;
			end
			m_cnt = k ? 5 : 255;
			rd(TBSCR_ADDR_DRV_TEST);
		end
		selftest_pass = 1;
		selftest_done = 1;
		@(negedge clk);
		selftest_done = 0;
		@(negedge clk);
		chk(16'(selftest_pass_flag), 16'h0001);
		selftest_start = 0;
		repeat (2) @(negedge clk);
		chk(16'(selftest_pass_flag), 16'h0000);
		for (k = 0; k < 2; k++)
		begin
			wr(TBSCR_ADDR_DRV_TEST, 'h10 | k << 2);
			repeat (2) @(negedge clk);
			pattern_seq_done = 1;
			n = 0;
			repeat (1000)
			begin
				@(negedge clk);
				pattern_seq_done = 0;
				n += test_ctl.gap_active;
			end
			chk(16'(n), 16'(k ? TBSCR_GAP_LONG_CYC : TBSCR_GAP_SHORT_CYC));
		end
		// Second reset with the strap low: serial bit must follow it
		rst = 1;
		strap_serial = 0;
		repeat (6) @(negedge clk);
		rst = 0;
		m_ctl = 'h0800;
		m_tst = 0;
		m_cnt = 0;
		m_pol = 0;
		@(negedge clk);
		rd(TBSCR_ADDR_TEN_CTRL);
		rd(TBSCR_ADDR_DRV_TEST);
		chk(16'(ten_ctl.serial_if_mode), 16'h0000);
		report_and_stop;
	end
endmodule // test_tbscr_regs
